// ---- core/ort_exec.sv ----
/*
  Execute unit for table fetch, no-op, the four OR forms and rotate-left
  through carry, with its own 128 x 4 data memory, accumulator and flags.
  Assumes the instruction source holds instr_valid_i until it is taken, the
  lookup index registers are driven from logic on clk_sys_i, and the table
  memory returns data one machine cycle after the address is presented.
*/
// Functional notes
// RL1 - Table fetch: 9-bit prefix plus 7-bit address, takes two machine cycles
// RL2 - Table address is high index times 10H plus low index; entry goes to memory
// RL3 - OR memory into accumulator, memory untouched, only zero flag changes
// RL4 - OR immediate with working register, result to accumulator, zero flag only
// RL5 - Write-back OR of memory and accumulator to both, zero flag only
// RL6 - Write-back OR of immediate and working register to both, zero flag only
// RL7 - Rotate left one machine cycle, bit 3 goes to carry
// RL8 - Rotate left inserts old carry into bit 0
// RL9 - Rotated nibble to memory and accumulator, carry and zero updated
// RL10 - All-zero code completes in one cycle and changes nothing
// RL11 - Zero flag set when the 4-bit result is zero, else cleared
module ort_exec #(
  parameter int unsigned MC_CLKS = ort_pkg::MC_CLKS_DEF,
  parameter int unsigned IDXH_W  = 7
) (
  input  wire logic                                        clk_sys_i,
  input  wire logic                                        rst_i,
  input  wire logic                                        instr_valid_i,
  input  wire logic [ort_pkg::INSTR_W-1:0]                 instr_i,
  input  wire logic [ort_pkg::IDXL_W-1:0]                  lookup_index_low_i,
  input  wire logic [IDXH_W-1:0]                           lookup_index_high_i,
  input  wire logic [ort_pkg::NIB_W-1:0]                   rom_data_i,
  input  wire logic [ort_pkg::RADDR_W-1:0]                 dbg_addr_i,
  output logic                                             mc_tick_o,
  output logic                                             instr_ready_o,
  output logic                                             instr_done_o,
  output logic                                             instr_unknown_o,
  output logic                                             rom_rd_o,
  output logic [IDXH_W+ort_pkg::IDXL_W-1:0]                rom_addr_o,
  output logic [ort_pkg::NIB_W-1:0]                        accum_o,
  output logic                                             carry_flag_o,
  output logic                                             zero_flag_o,
  output logic [ort_pkg::NIB_W-1:0]                        dbg_data_o
);

  localparam int unsigned ROM_AW = IDXH_W + ort_pkg::IDXL_W;
  localparam int unsigned CNT_W  = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MC_CLKS - 1);

  // Refused at elaboration: a wider high index would overrun the 2K table space
  if (MC_CLKS < 1 || IDXH_W < 1 || IDXH_W > 7) begin : g_bad_param
    $error("ort_exec: unsupported parameter value");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [ort_pkg::NIB_W-1:0]   mem_ff [ort_pkg::MEM_DEPTH];
  logic [ort_pkg::NIB_W-1:0]   accum_ff;
  ort_pkg::ort_flags_t         flags_ff;
  ort_pkg::ort_state_t         state_ff;
  logic                        ready_ff;
  logic [CNT_W-1:0]            cnt_ff;
  logic                        tick_ff;
  logic                        done_ff;
  logic                        unknown_ff;
  logic                        rom_rd_ff;
  logic [ROM_AW-1:0]           rom_addr_ff;
  logic [ort_pkg::RADDR_W-1:0] fetch_dst_ff;
  logic [ort_pkg::NIB_W-1:0]   dbg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle enable from the core clock
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (cnt_ff == CNT_LAST);
      if (cnt_ff == CNT_LAST) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  ort_pkg::ort_dec_t dec;
  logic [8:0]        pfx9;
  logic [6:0]        pfx7;

  always_comb begin
    pfx9      = instr_i[ort_pkg::PFX9_LSB +: 9];
    pfx7      = instr_i[ort_pkg::PFX7_LSB +: 7];
    dec.raddr = instr_i[ort_pkg::RADDR_W-1:0];
    dec.imm   = instr_i[ort_pkg::IMM_LSB +: ort_pkg::NIB_W];
    dec.wsel  = instr_i[ort_pkg::WSEL_LSB +: ort_pkg::NIB_W];
    if (instr_i == ort_pkg::CODE_NOP) begin
      dec.op = ort_pkg::ORT_OP_NOP;                         // see RL10
    end else if (pfx9 == ort_pkg::PFX_TABLE_FETCH) begin
      dec.op = ort_pkg::ORT_OP_FETCH;                       // see RL1
    end else if (pfx9 == ort_pkg::PFX_OR_MEM) begin
      dec.op = ort_pkg::ORT_OP_OR_M;
    end else if (pfx9 == ort_pkg::PFX_OR_MEM_WB) begin
      dec.op = ort_pkg::ORT_OP_OR_MWB;
    end else if (pfx9 == ort_pkg::PFX_ROT_LEFT) begin
      dec.op = ort_pkg::ORT_OP_ROTL;                        // see RL7
    end else if (!instr_i[ort_pkg::INSTR_W-1] && pfx7 == ort_pkg::PFX_OR_IMM) begin
      dec.op = ort_pkg::ORT_OP_OR_I;
    end else if (!instr_i[ort_pkg::INSTR_W-1] && pfx7 == ort_pkg::PFX_OR_IMM_WB) begin
      dec.op = ort_pkg::ORT_OP_OR_IWB;
    end else begin
      dec.op = ort_pkg::ORT_OP_OTHER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  logic                        take;
  logic [ort_pkg::NIB_W-1:0]   mem_rd;
  logic [ort_pkg::NIB_W-1:0]   wr_rd;
  logic [ort_pkg::NIB_W-1:0]   result;
  logic                        res_to_acc;
  logic                        upd_zero;
  logic                        upd_carry;
  logic                        nxt_carry;
  logic                        mem_we;
  logic [ort_pkg::RADDR_W-1:0] mem_waddr;
  logic [ort_pkg::NIB_W-1:0]   mem_wdata;
  logic                        fetch_done;

  assign take       = tick_ff && instr_valid_i && (state_ff == ort_pkg::ORT_ST_IDLE);
  assign fetch_done = tick_ff && (state_ff == ort_pkg::ORT_ST_FETCH);
  assign mem_rd     = mem_ff[dec.raddr];
  assign wr_rd      = mem_ff[{3'h0, dec.wsel}];

  always_comb begin
    result     = ort_pkg::NIB_ZERO;
    res_to_acc = 1'b0;
    upd_zero   = 1'b0;
    upd_carry  = 1'b0;
    nxt_carry  = flags_ff.carry_flag;
    mem_we     = 1'b0;
    mem_waddr  = dec.raddr;
    mem_wdata  = ort_pkg::NIB_ZERO;
    if (fetch_done) begin
      mem_we    = 1'b1;                                     // see RL2
      mem_waddr = fetch_dst_ff;
      mem_wdata = rom_data_i;
    end else if (take) begin
      unique case (dec.op)
        ort_pkg::ORT_OP_OR_M: begin
          result     = mem_rd | accum_ff;                   // see RL3
          res_to_acc = 1'b1;
          upd_zero   = 1'b1;
        end
        ort_pkg::ORT_OP_OR_I: begin
          result     = wr_rd | dec.imm;                     // see RL4
          res_to_acc = 1'b1;
          upd_zero   = 1'b1;
        end
        ort_pkg::ORT_OP_OR_MWB: begin
          result     = mem_rd | accum_ff;                   // see RL5
          res_to_acc = 1'b1;
          upd_zero   = 1'b1;
          mem_we     = 1'b1;
          mem_wdata  = result;
        end
        ort_pkg::ORT_OP_OR_IWB: begin
          result     = wr_rd | dec.imm;                     // see RL6
          res_to_acc = 1'b1;
          upd_zero   = 1'b1;
          mem_we     = 1'b1;
          mem_waddr  = {3'h0, dec.wsel};
          mem_wdata  = result;
        end
        ort_pkg::ORT_OP_ROTL: begin
          result     = {mem_rd[2:0], flags_ff.carry_flag};  // see RL7, see RL8
          nxt_carry  = mem_rd[3];                           // see RL7
          res_to_acc = 1'b1;                                // see RL9
          upd_zero   = 1'b1;
          upd_carry  = 1'b1;
          mem_we     = 1'b1;
          mem_wdata  = result;
        end
        // No-op, table fetch start and foreign codes touch nothing here
        ort_pkg::ORT_OP_NOP,
        ort_pkg::ORT_OP_FETCH,
        ort_pkg::ORT_OP_OTHER: begin
          result = ort_pkg::NIB_ZERO;                       // see RL10
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory, working registers are locations 0 to 15
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < int'(ort_pkg::MEM_DEPTH); i++) begin
        mem_ff[i] <= ort_pkg::NIB_ZERO;
      end
    end else if (mem_we) begin
      mem_ff[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      accum_ff <= ort_pkg::NIB_ZERO;
    end else if (res_to_acc) begin
      accum_ff <= result;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flags_ff <= '0;
    end else begin
      if (upd_zero) begin
        flags_ff.zero_flag <= (result == ort_pkg::NIB_ZERO);    // see RL11
      end
      if (upd_carry) begin
        flags_ff.carry_flag <= nxt_carry;                       // see RL9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: table fetch holds for a second machine cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff     <= ort_pkg::ORT_ST_IDLE;
      ready_ff     <= 1'b1;
      rom_rd_ff    <= 1'b0;
      rom_addr_ff  <= '0;
      fetch_dst_ff <= '0;
    end else if (take && dec.op == ort_pkg::ORT_OP_FETCH) begin
      state_ff     <= ort_pkg::ORT_ST_FETCH;                    // see RL1
      ready_ff     <= 1'b0;
      rom_rd_ff    <= 1'b1;
      // Low index is below 10H, so times 10H plus low is a concatenation
      rom_addr_ff  <= {lookup_index_high_i, lookup_index_low_i}; // see RL2
      fetch_dst_ff <= dec.raddr;
    end else if (fetch_done) begin
      state_ff  <= ort_pkg::ORT_ST_IDLE;
      ready_ff  <= 1'b1;
      rom_rd_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      done_ff    <= 1'b0;
      unknown_ff <= 1'b0;
    end else begin
      done_ff    <= fetch_done || (take && dec.op != ort_pkg::ORT_OP_FETCH);
      unknown_ff <= take && dec.op == ort_pkg::ORT_OP_OTHER;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dbg_ff <= ort_pkg::NIB_ZERO;
    end else begin
      dbg_ff <= mem_ff[dbg_addr_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign mc_tick_o       = tick_ff;
  assign instr_ready_o   = ready_ff;
  assign instr_done_o    = done_ff;
  assign instr_unknown_o = unknown_ff;
  assign rom_rd_o        = rom_rd_ff;
  assign rom_addr_o      = rom_addr_ff;
  assign accum_o         = accum_ff;
  assign carry_flag_o    = flags_ff.carry_flag;
  assign zero_flag_o     = flags_ff.zero_flag;
  assign dbg_data_o      = dbg_ff;

endmodule

// ---- core/ort_pkg.sv ----
/*
  Constants, encodings and carrier types for the OR / rotate / table-fetch
  execute block of a 4-bit core.
  Assumes a 16-bit instruction word with printed codes aligned to bit 0.
*/
package ort_pkg;

  localparam int unsigned INSTR_W   = 16;
  localparam int unsigned NIB_W     = 4;
  localparam int unsigned RADDR_W   = 7;
  localparam int unsigned MEM_DEPTH = 128;
  localparam int unsigned IDXL_W    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode prefixes: 9-bit forms sit in [15:7], 7-bit forms in [14:8]
  localparam logic [8:0] PFX_TABLE_FETCH = 9'h132;  // 1 0011 0010
  localparam logic [8:0] PFX_OR_MEM      = 9'h074;  // 0 0111 0100
  localparam logic [8:0] PFX_OR_MEM_WB   = 9'h076;  // 0 0111 0110
  localparam logic [8:0] PFX_ROT_LEFT    = 9'h099;  // 0 1001 1001
  localparam logic [6:0] PFX_OR_IMM      = 7'h1e;   // 001 1110
  localparam logic [6:0] PFX_OR_IMM_WB   = 7'h1f;   // 001 1111
  localparam logic [INSTR_W-1:0] CODE_NOP = 16'h0000;

  localparam int unsigned PFX9_LSB = 7;
  localparam int unsigned PFX7_LSB = 8;
  localparam int unsigned IMM_LSB  = 4;
  localparam int unsigned WSEL_LSB = 0;

  localparam int unsigned FETCH_CYCLES = 2;
  localparam int unsigned MC_CLKS_DEF  = 4;

  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ORT_OP_NOP    = 3'h0,
    ORT_OP_FETCH  = 3'h1,
    ORT_OP_OR_M   = 3'h2,
    ORT_OP_OR_I   = 3'h3,
    ORT_OP_OR_MWB = 3'h4,
    ORT_OP_OR_IWB = 3'h5,
    ORT_OP_ROTL   = 3'h6,
    ORT_OP_OTHER  = 3'h7
  } ort_op_t;

  typedef enum logic [0:0] {
    ORT_ST_IDLE  = 1'b0,
    ORT_ST_FETCH = 1'b1
  } ort_state_t;

  typedef struct packed {
    logic carry_flag;
    logic zero_flag;
  } ort_flags_t;

  typedef struct packed {
    ort_op_t              op;
    logic [RADDR_W-1:0]   raddr;
    logic [NIB_W-1:0]     imm;
    logic [NIB_W-1:0]     wsel;
  } ort_dec_t;

endpackage

// ---- tb/ort_exec_checker.sv ----
/*
  Concurrent checks on the ports of ort_exec.
  Assumes the one clock domain of clk_sys_i with rst_i as disable.
*/
module ort_exec_checker #(
  parameter int unsigned MC_CLKS = 4,
  parameter int unsigned IDXH_W  = 7
) (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic                instr_valid_i,
  input wire logic [15:0]         instr_i,
  input wire logic [3:0]          lookup_index_low_i,
  input wire logic [IDXH_W-1:0]   lookup_index_high_i,
  input wire logic                mc_tick_o,
  input wire logic                instr_ready_o,
  input wire logic                instr_done_o,
  input wire logic                rom_rd_o,
  input wire logic [IDXH_W+3:0]   rom_addr_o,
  input wire logic [3:0]          accum_o,
  input wire logic                carry_flag_o,
  input wire logic                zero_flag_o
);
  wire take = mc_tick_o && instr_valid_i && instr_ready_o;
  wire t_orm = take && instr_i[15:7] == ort_pkg::PFX_OR_MEM;
  wire t_ori = take && (instr_i[15:8] == {1'b0, ort_pkg::PFX_OR_IMM} ||
                        instr_i[15:8] == {1'b0, ort_pkg::PFX_OR_IMM_WB});
  wire t_rot = take && instr_i[15:7] == ort_pkg::PFX_ROT_LEFT;
  wire t_alu = t_orm || t_ori || t_rot || (take && instr_i[15:7] == ort_pkg::PFX_OR_MEM_WB);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fetch_take;
    take && instr_i[15:7] == ort_pkg::PFX_TABLE_FETCH;
  endsequence
  sequence s_fetch_wait;
    !instr_ready_o && rom_rd_o && !instr_done_o;
  endsequence
  AST_FETCH_HOLD: assert property (s_fetch_take |=> s_fetch_wait)
    else $error("fetch did not hold a second machine cycle");
  AST_FETCH_END: assert property (s_fetch_take |-> ##[2:64] instr_done_o)
    else $error("fetch never completed");
  AST_FETCH_ADDR: assert property (s_fetch_take |=>
    rom_addr_o == {$past(lookup_index_high_i), $past(lookup_index_low_i)})
    else $error("table address is not high times 16 plus low");
  AST_FETCH_FLAGS: assert property (s_fetch_take |=> $stable(carry_flag_o) && $stable(zero_flag_o))
    else $error("fetch changed a flag");
  AST_OR_MEM: assert property (t_orm |=> (accum_o | $past(accum_o)) == accum_o && $stable(carry_flag_o))
    else $error("memory OR lost accumulator bits or touched carry");
  AST_OR_IMM: assert property (t_ori |=> (accum_o | $past(instr_i[7:4])) == accum_o && $stable(carry_flag_o))
    else $error("immediate OR lost immediate bits or touched carry");
  AST_ROT_IN: assert property (t_rot |=> accum_o[0] == $past(carry_flag_o))
    else $error("rotate did not bring old carry into bit 0");
  AST_ZERO: assert property (t_alu |=> zero_flag_o == (accum_o == 4'h0))
    else $error("zero flag does not match result");
  AST_NOP: assert property (take && instr_i == ort_pkg::CODE_NOP |=>
    instr_done_o && $stable(accum_o) && $stable(carry_flag_o) && $stable(zero_flag_o))
    else $error("no-op changed state or did not finish");
endmodule

bind ort_exec ort_exec_checker #(.MC_CLKS(MC_CLKS), .IDXH_W(IDXH_W)) u_ort_exec_checker (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .lookup_index_low_i(lookup_index_low_i), .lookup_index_high_i(lookup_index_high_i),
  .mc_tick_o(mc_tick_o), .instr_ready_o(instr_ready_o), .instr_done_o(instr_done_o),
  .rom_rd_o(rom_rd_o), .rom_addr_o(rom_addr_o), .accum_o(accum_o),
  .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o));

// ---- tb/ort_exec_test.sv ----
/*
  Self-checking bench for ort_exec: random instruction mix against a model.
  Assumes a tick every clock (MC_CLKS 1) and the table model on the far side.
*/
module ort_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        vld = 1'b0;
  logic [15:0] ins = 16'h0000;
  logic [3:0]  lo = 4'h0;
  logic [6:0]  hi = 7'h00;
  logic [6:0]  dbg_a = 7'h00;
  logic [3:0]  rom_d, acc_o, dbg_d, em [128], acc, i, w, v;
  logic [10:0] rom_a, a;
  logic        tick, rdy, done, unk, rom_rd, cf_o, zf_o, cf, zf, t;
  int          error_cnt, n_compared, cyc;
  always #5 clk_sys_i = ~clk_sys_i;
  ort_exec #(.MC_CLKS(1), .IDXH_W(7)) u_ort_exec (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(vld), .instr_i(ins),
    .lookup_index_low_i(lo), .lookup_index_high_i(hi), .rom_data_i(rom_d), .dbg_addr_i(dbg_a),
    .mc_tick_o(tick), .instr_ready_o(rdy), .instr_done_o(done), .instr_unknown_o(unk),
    .rom_rd_o(rom_rd), .rom_addr_o(rom_a), .accum_o(acc_o), .carry_flag_o(cf_o),
    .zero_flag_o(zf_o), .dbg_data_o(dbg_d));
  ort_rom_model u_ort_rom_model (.clk_sys_i(clk_sys_i), .rom_rd_i(rom_rd), .rom_addr_i(rom_a), .rom_data_o(rom_d));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task run(input int k);
    logic [6:0] r;
    int n;
    @(posedge clk_sys_i);
    #1;
    r = $urandom;
    i = $urandom;
    w = $urandom;
    hi = $urandom;
    lo = $urandom;
    a = {hi, lo};
    case (k)
      0: ins = ort_pkg::CODE_NOP;
      1: ins = {ort_pkg::PFX_TABLE_FETCH, r};
      2: ins = {ort_pkg::PFX_OR_MEM, r};
      3: ins = {1'b0, ort_pkg::PFX_OR_IMM, i, w};
      4: ins = {ort_pkg::PFX_OR_MEM_WB, r};
      5: ins = {1'b0, ort_pkg::PFX_OR_IMM_WB, i, w};
      6: ins = {ort_pkg::PFX_ROT_LEFT, r};
      // Code outside this set: must act as a no-op and raise the unknown pulse
      default: ins = {9'h1ff, r};
    endcase
    // Working register n is data memory location n
    if (k == 3 || k == 5) r = {3'h0, w};
    v = em[r];
    case (k)
      1: em[r] = a[3:0] ^ a[7:4] ^ {1'b0, a[10:8]};
      2, 4: acc = v | acc;
      3, 5: acc = v | i;
      6: begin
        acc = {v[2:0], cf};
        cf = v[3];
      end
      default: ;
    endcase
    if (k >= 4 && k <= 6) em[r] = acc;
    if (k > 1 && k < 7) zf = (acc == 4'h0);
    dbg_a = r;
    vld = 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      t = tick & rdy;
      @(posedge clk_sys_i);
      n++;
    end while (t !== 1'b1 && n < 50);
    #1 vld = 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (done !== 1'b1 && n < 50);
    chk(16'(done), 16'h1);
    chk(16'(unk), 16'(k == 7));
    chk(16'({tick, rdy, rom_rd}), 16'h6);
    chk(16'(acc_o), 16'(acc));
    chk(16'({cf_o, zf_o}), 16'({cf, zf}));
    // The observed location is registered, so a write shows one clock later
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(16'(dbg_d), 16'(em[r]));
    if (k == 1) chk(16'(rom_a), 16'(a));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    foreach (em[j]) em[j] = 4'h0;
    {acc, cf, zf} = '0;
    void'($urandom(32'hfbec));
    repeat (8) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    for (int k = 0; k < 8; k++) run(k);
    $display("test each_op done");
    for (int n = 0; n < 150; n++) run($urandom_range(0, 7));
    $display("test random_mix done");
    stop_test();
  end
endmodule

// ---- tb/ort_rom_model.sv ----
/*
  Table memory on the far side of the execute block.
  Assumes reads are combinational on the address while rom_rd_i is high.
*/
module ort_rom_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rom_rd_i,
  input  wire logic [10:0] rom_addr_i,
  output logic      [3:0]  rom_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] entry;
  logic [3:0] last_ff = 4'h0;
  // Entry depends on every address bit so a wrong index shows up
  assign entry = rom_addr_i[3:0] ^ rom_addr_i[7:4] ^ {1'b0, rom_addr_i[10:8]};
  // Outside a read the bus shows the inverse of the last entry, never a stale value
  assign rom_data_o = rom_rd_i ? entry : ~last_ff;
  always @(posedge clk_sys_i) begin
    if (rom_rd_i) last_ff <= entry;
  end
endmodule
